// ==== design/mnd_decode.sv ====
// package and opcode decoder for the move / no-op / return-from-interrupt core

// ****************************************************************
// shared constants and types
// ****************************************************************
package mnd_pkg;
	// instruction word and operand geometry
	localparam int INSTR_W      = 14;
	localparam int FADDR_W      = 7;
	localparam int DATA_W       = 8;
	localparam int FREG_COUNT   = 128;
	localparam int DEST_BIT     = 7;
	// opcode fields
	localparam logic [5:0] FMOVE_CODE = 6'h08;
	localparam logic [3:0] LLOAD_CODE = 4'hc;
	localparam logic [6:0] STORE_CODE = 7'h01;
	localparam logic [6:0] NOP_HI     = 7'h00;
	localparam logic [4:0] NOP_LO     = 5'h00;
	localparam logic [13:0] IRET_CODE = 14'h0009;
	// interrupt control register layout and reset
	localparam int IRQ_EN_BIT           = 7;
	localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
	// timing: four clocks make one instruction cycle
	localparam int CLK_PERIOD_NS   = 50;
	localparam int INSTR_PERIOD_NS = 200;
	localparam int Q_PER_CYCLE     = INSTR_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [1:0] Q_FIRST = 2'h0;
	localparam logic [1:0] Q_LAST  = 2'(Q_PER_CYCLE - 1);
	// reset values
	localparam logic [7:0] W_RST    = 8'h00;
	localparam logic [7:0] FREG_RST = 8'h00;

	typedef enum logic [2:0] {
		OTHER_OP,
		FILE_MOVE_OP,
		LITERAL_LOAD_OP,
		WORK_STORE_OP,
		NO_OPERATION_OP,
		INTERRUPT_RETURN_OP
	} mnd_op_e;
endpackage : mnd_pkg

// ****************************************************************
// combinational opcode decoder
// ****************************************************************
module mnd_decode
	import mnd_pkg::*;
(
	// instruction word
	input  wire logic [INSTR_W-1:0] instr_in,
	// decoded fields
	output mnd_op_e                 op_out,
	output logic                    dest_out,
	output logic [FADDR_W-1:0]      faddr_out,
	output logic [DATA_W-1:0]       lit_out
);
	// operand fields are fixed slices of the word
	assign dest_out  = instr_in[DEST_BIT];         // see RULE1
	assign faddr_out = instr_in[FADDR_W-1:0];      // see RULE10
	assign lit_out   = instr_in[DATA_W-1:0];       // see RULE10

	// exact return code is checked before the looser no-op pattern
	always_comb begin
		if (instr_in == IRET_CODE) begin
			op_out = INTERRUPT_RETURN_OP;          // see RULE6
		end else if (instr_in[13:8] == FMOVE_CODE) begin
			op_out = FILE_MOVE_OP;                 // see RULE1
		end else if (instr_in[13:10] == LLOAD_CODE) begin
			op_out = LITERAL_LOAD_OP;              // bits 9:8 ignored, see RULE4
		end else if (instr_in[13:7] == STORE_CODE) begin
			op_out = WORK_STORE_OP;                // see RULE5
		end else if (instr_in[13:7] == NOP_HI &&
				instr_in[4:0] == NOP_LO) begin
			op_out = NO_OPERATION_OP;              // bits 6:5 ignored, see RULE9
		end else begin
			op_out = OTHER_OP;
		end
	end
endmodule : mnd_decode

// ==== design/mnd_core.sv ====
// execute core for file move, literal load, store, no-op and interrupt return
//
// Contract
// RULE1: file move copies f into W when d is 0, into f when d is 1.
// RULE2: file move sets zero flag from the moved value.
// RULE3: literal load puts the 8-bit literal in W, flags untouched.
// RULE4: the two don't-care bits of literal load never alter decoding.
// RULE5: store writes W into file register at 7-bit address, flags untouched.
// RULE6: interrupt return pops the stack and loads the popped value into PC.
// RULE7: interrupt return sets global interrupt enable, bit 7 of control reg.
// RULE8: interrupt return takes two instruction cycles, the others take one.
// RULE9: no-operation changes nothing except advancing the program counter.
// RULE10: file operands from the low 7 bits, literals from the low 8.
module mnd_core
	import mnd_pkg::*;
#(
	parameter int PC_W        = 13,
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input  wire logic               mclk_in,
	input  wire logic               sys_rst_in,
	// instruction from program memory, valid for the cycle at pc_out
	input  wire logic [INSTR_W-1:0] instr_in,
	// stack push and interrupt entry from the rest of the core
	input  wire logic               stack_push_in,
	input  wire logic [PC_W-1:0]    stack_push_addr_in,
	input  wire logic               irq_en_clear_in,
	// architectural state
	output logic [PC_W-1:0]         pc_out,
	output logic [DATA_W-1:0]       w_out,
	output logic                    zero_flag_out,
	output logic [7:0]              interrupt_control_reg_out,
	output logic                    cycle_end_out,
	// file register write observation
	output logic                    fwr_en_out,
	output logic [FADDR_W-1:0]      fwr_addr_out,
	output logic [DATA_W-1:0]       fwr_data_out
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [1:0]         q_r;
	logic [INSTR_W-1:0] ir_r;
	logic               flush_r;
	logic [PC_W-1:0]    pc_r;
	logic [DATA_W-1:0]  w_r;
	logic               z_r;
	logic [7:0]         irq_ctrl_r;
	logic [SP_W-1:0]    sp_r;
	logic [PC_W-1:0]    stack_r [STACK_DEPTH];
	logic [DATA_W-1:0]  fregs_r [FREG_COUNT];
	logic               fwr_en_r;
	logic [FADDR_W-1:0] fwr_addr_r;
	logic [DATA_W-1:0]  fwr_data_r;
	logic               cyc_end_r;

	// decoded view of the latched instruction
	mnd_op_e            op;
	logic               dest;
	logic [FADDR_W-1:0] faddr;
	logic [DATA_W-1:0]  lit;
	logic [DATA_W-1:0]  fdata;
	logic [PC_W-1:0]    stack_top;
	logic               exec;

	mnd_decode u_decode (
		.instr_in  (ir_r),
		.op_out    (op),
		.dest_out  (dest),
		.faddr_out (faddr),
		.lit_out   (lit)
	);

	assign fdata     = fregs_r[faddr];
	assign stack_top = stack_r[SP_W'(sp_r - 1'b1)];
	// the cycle after an interrupt return is a dead slot
	assign exec      = (q_r == Q_LAST) && !flush_r;

	// ****************************************************************
	// instruction cycle sequencing
	// ****************************************************************
	// phase counter: four clocks per instruction cycle
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			q_r       <= Q_FIRST;
			cyc_end_r <= 1'b0;
		end else begin
			q_r       <= (q_r == Q_LAST) ? Q_FIRST : 2'(q_r + 1'b1);
			cyc_end_r <= (q_r == Q_LAST);
		end
	end

	// fetch latch: word taken at first phase from the current pc
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ir_r <= '0;
		end else if (q_r == Q_FIRST) begin
			ir_r <= instr_in;
		end
	end

	// second cycle of interrupt return: fetched word is discarded
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			flush_r <= 1'b0;
		end else if (q_r == Q_LAST) begin
			flush_r <= exec && (op == INTERRUPT_RETURN_OP); // see RULE8
		end
	end

	// ****************************************************************
	// program counter and stack
	// ****************************************************************
	// pc advances once per executed cycle, return reloads from stack
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pc_r <= '0;
		end else if (exec) begin
			if (op == INTERRUPT_RETURN_OP) begin
				pc_r <= stack_top;                    // see RULE6
			end else begin
				pc_r <= PC_W'(pc_r + 1'b1);           // see RULE9
			end
		end
	end

	// circular stack: overflow and underflow wrap silently
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sp_r <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_r[i] <= '0;
			end
		end else if (exec && op == INTERRUPT_RETURN_OP) begin
			sp_r <= SP_W'(sp_r - 1'b1);               // see RULE6
		end else if (stack_push_in) begin
			stack_r[sp_r] <= stack_push_addr_in;
			sp_r          <= SP_W'(sp_r + 1'b1);
		end
	end

	// ****************************************************************
	// working register, zero flag, interrupt control
	// ****************************************************************
	// w loads from a move with d clear or from a literal
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			w_r <= W_RST;
		end else if (exec) begin
			if (op == FILE_MOVE_OP && !dest) begin
				w_r <= fdata;                         // see RULE1
			end else if (op == LITERAL_LOAD_OP) begin
				w_r <= lit;                           // see RULE3
			end
		end
	end

	// only the file move touches the zero flag here
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			z_r <= 1'b0;
		end else if (exec && op == FILE_MOVE_OP) begin
			z_r <= (fdata == '0);                     // see RULE2
		end
	end

	// the return's set beats a clear in the same clock
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			irq_ctrl_r <= IRQ_CTRL_RST;
		end else if (exec && op == INTERRUPT_RETURN_OP) begin
			irq_ctrl_r[IRQ_EN_BIT] <= 1'b1;           // see RULE7
		end else if (irq_en_clear_in) begin
			irq_ctrl_r[IRQ_EN_BIT] <= 1'b0;
		end
	end

	// ****************************************************************
	// file registers
	// ****************************************************************
	// move with d set rewrites f with itself, a cheap zero test
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			fwr_en_r   <= 1'b0;
			fwr_addr_r <= '0;
			fwr_data_r <= '0;
			for (int i = 0; i < FREG_COUNT; i++) begin
				fregs_r[i] <= FREG_RST;
			end
		end else begin
			fwr_en_r <= 1'b0;
			if (exec && op == FILE_MOVE_OP && dest) begin
				fregs_r[faddr] <= fdata;              // see RULE1
				fwr_en_r       <= 1'b1;
				fwr_addr_r     <= faddr;
				fwr_data_r     <= fdata;
			end else if (exec && op == WORK_STORE_OP) begin
				fregs_r[faddr] <= w_r;                // see RULE5
				fwr_en_r       <= 1'b1;
				fwr_addr_r     <= faddr;              // see RULE10
				fwr_data_r     <= w_r;
			end
		end
	end

	// outputs straight from flip-flops
	assign pc_out                    = pc_r;
	assign w_out                     = w_r;
	assign zero_flag_out             = z_r;
	assign interrupt_control_reg_out = irq_ctrl_r;
	assign cycle_end_out             = cyc_end_r;
	assign fwr_en_out                = fwr_en_r;
	assign fwr_addr_out              = fwr_addr_r;
	assign fwr_data_out              = fwr_data_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	a_move_to_w: assert property ( // see RULE1
		exec && op == FILE_MOVE_OP && !dest |=> w_r == $past(fdata))
		else $error("file move did not load w");
	a_move_zero: assert property ( // see RULE2
		exec && op == FILE_MOVE_OP |=> z_r == ($past(fdata) == 8'h00))
		else $error("file move zero flag wrong");
	a_literal_load: assert property ( // see RULE3
		exec && op == LITERAL_LOAD_OP |=> w_r == $past(lit) && $stable(z_r))
		else $error("literal load wrong");
	a_literal_dontcare: assert property ( // see RULE4
		ir_r[13:10] == LLOAD_CODE |-> op == LITERAL_LOAD_OP)
		else $error("literal load decode depends on dont-care bits");
	a_store_write: assert property ( // see RULE5
		exec && op == WORK_STORE_OP |=> fwr_en_r && fwr_data_r == $past(w_r)
			&& fwr_addr_r == $past(ir_r[6:0]) && $stable(z_r))
		else $error("store write wrong");
	a_return_pc: assert property ( // see RULE6
		exec && op == INTERRUPT_RETURN_OP |=> pc_r == $past(stack_top)
			&& sp_r == SP_W'($past(sp_r) - 1'b1))
		else $error("interrupt return pc or pop wrong");
	a_return_enable: assert property ( // see RULE7
		exec && op == INTERRUPT_RETURN_OP |=> irq_ctrl_r[IRQ_EN_BIT])
		else $error("interrupt return did not set enable");
	// dead slot: no execute at its phase 3, pc held until the next one
	a_return_two_cycles: assert property ( // see RULE8
		exec && op == INTERRUPT_RETURN_OP |=> (##3 !exec ##4 exec)
			and (##1 $stable(pc_r)[*7]))
		else $error("interrupt return not two cycles");
	a_single_cycle: assert property ( // see RULE8
		exec && op != INTERRUPT_RETURN_OP |=> ##3 exec)
		else $error("one-cycle instruction stalled");
	a_nop_quiet: assert property ( // see RULE9
		exec && op == NO_OPERATION_OP |=> $stable(w_r) && $stable(z_r)
			&& !fwr_en_r && pc_r == PC_W'($past(pc_r) + 1'b1))
		else $error("no-op changed state");
	a_operand_slice: assert property ( // see RULE10
		exec && op == FILE_MOVE_OP && dest |=> fwr_addr_r == $past(ir_r[6:0]))
		else $error("file operand not from low bits");
endmodule : mnd_core

// ==== dv/test_move_nop_interrupt_return_op_decode.sv ====
// self-checking testbench for the move / no-op / interrupt-return core
module test_move_nop_interrupt_return_op_decode
	import mnd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************************
	// signals and bench state
	// ****************************************************************
	localparam int DRV = 1;
	logic                 mclk_in;
	logic                 sys_rst_in;
	logic [INSTR_W-1:0]   instr_in;
	logic                 stack_push_in;
	logic [12:0]          stack_push_addr_in;
	logic                 irq_en_clear_in;
	logic [12:0]          pc_out;
	logic [DATA_W-1:0]    w_out;
	logic                 zero_flag_out;
	logic [7:0]           interrupt_control_reg_out;
	logic                 cycle_end_out;
	logic                 fwr_en_out;
	logic [FADDR_W-1:0]   fwr_addr_out;
	logic [DATA_W-1:0]    fwr_data_out;
	int                   miscompares;
	int                   compares;
	logic [12:0]          exp_pc;
	logic [12:0]          stk[$];
	logic                 skip;

	mnd_core uut (
		.mclk_in                   (mclk_in),
		.sys_rst_in                (sys_rst_in),
		.instr_in                  (instr_in),
		.stack_push_in             (stack_push_in),
		.stack_push_addr_in        (stack_push_addr_in),
		.irq_en_clear_in           (irq_en_clear_in),
		.pc_out                    (pc_out),
		.w_out                     (w_out),
		.zero_flag_out             (zero_flag_out),
		.interrupt_control_reg_out (interrupt_control_reg_out),
		.cycle_end_out             (cycle_end_out),
		.fwr_en_out                (fwr_en_out),
		.fwr_addr_out              (fwr_addr_out),
		.fwr_data_out              (fwr_data_out)
	);

	// 50 ns clock
	always #25 mclk_in = ~mclk_in;

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
			input string what);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	// one instruction cycle: word latched at phase 0, results after phase 3
	task automatic exec(input logic [13:0] word, input logic wr);
		instr_in = word;
		// the word after an interrupt return is thrown away, pc held
		if (skip) begin
			skip = 1'b0;
		end else if (word === IRET_CODE) begin
			exp_pc = stk.pop_back();
			skip = 1'b1;
		end else begin
			exp_pc = exp_pc + 13'h0001;
		end
		@(posedge mclk_in);
		#DRV;
		stack_push_in = 1'b0;
		irq_en_clear_in = 1'b0;
		// both pulses must have dropped after one clock
		check(16'(cycle_end_out), 16'h0000, "cycle end low");
		check(16'(fwr_en_out), 16'h0000, "strobe low");
		repeat (3) @(posedge mclk_in);
		#DRV;
		check(16'(cycle_end_out), 16'h0001, "cycle end");
		check(16'(pc_out), 16'(exp_pc), "pc");
		check(16'(fwr_en_out), 16'(wr), "write strobe");
	endtask : exec

	// a no-op cycle carrying a stack push and / or an enable clear
	task automatic side_op(input logic push, input logic [12:0] addr,
			input logic clr);
		stack_push_in = push;
		stack_push_addr_in = addr;
		irq_en_clear_in = clr;
		if (push) stk.push_back(addr);
		exec(14'h0000, 1'b0);
	endtask : side_op

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic sc_move;
		exec(14'h0800, 1'b0);
		check(16'(w_out), 16'h0000, "move to w");
		check(16'(zero_flag_out), 16'h0001, "zero set");
		exec(14'h3042, 1'b0);
		exec(14'h00ff, 1'b1);
		check(16'(fwr_addr_out), 16'h007f, "top address");
		exec(14'h3000, 1'b0);
		exec(14'h087f, 1'b0);
		check(16'(w_out), 16'h0042, "move f127");
		check(16'(zero_flag_out), 16'h0000, "zero clear");
		// d set: rewrite f127 in place, w must not move
		exec(14'h08ff, 1'b1);
		check(16'(fwr_data_out), 16'h0042, "rewrite data");
		check(16'(fwr_addr_out), 16'h007f, "rewrite addr");
		check(16'(w_out), 16'h0042, "w kept");
		// in-place test of a zero register
		exec(14'h0880, 1'b1);
		check(16'(zero_flag_out), 16'h0001, "zero test");
	endtask : sc_move

	task automatic sc_literal;
		logic [7:0] lits[4];
		lits = '{8'h5a, 8'ha5, 8'h00, 8'hff};
		for (int i = 0; i < 4; i++) begin
			exec({LLOAD_CODE, 2'(i), lits[i]}, 1'b0);
			check(16'(w_out), 16'(lits[i]), "literal");
			check(16'(zero_flag_out), 16'h0001, "flag kept");
		end
	endtask : sc_literal

	task automatic sc_store;
		exec(14'h0085, 1'b1);
		check(16'(fwr_addr_out), 16'h0005, "store addr");
		check(16'(fwr_data_out), 16'h00ff, "store data");
		check(16'(zero_flag_out), 16'h0001, "store flag");
	endtask : sc_store

	task automatic sc_nop;
		for (int i = 0; i < 4; i++) begin
			exec({7'h00, 2'(i), 5'h00}, 1'b0);
			check(16'(w_out), 16'h00ff, "nop w");
			check(16'(zero_flag_out), 16'h0001, "nop flag");
		end
	endtask : sc_nop

	task automatic sc_iret;
		side_op(1'b1, 13'h0123, 1'b0);
		side_op(1'b1, 13'h1abc, 1'b0);
		exec(IRET_CODE, 1'b0);
		check(16'(pc_out), 16'h1abc, "return pc");
		check(16'(interrupt_control_reg_out), 16'h0080, "enable");
		// second cycle of the return: this load must not land
		exec(14'h3077, 1'b0);
		check(16'(w_out), 16'h00ff, "discarded");
		// clear the enable so the next return has something to set
		side_op(1'b0, 13'h0000, 1'b1);
		check(16'(interrupt_control_reg_out), 16'h0000, "cleared");
		exec(IRET_CODE, 1'b0);
		check(16'(pc_out), 16'h0123, "second pop");
		check(16'(interrupt_control_reg_out), 16'h0080, "re-enable");
		exec(14'h0000, 1'b0);
		exec(14'h3011, 1'b0);
		check(16'(w_out), 16'h0011, "after return");
	endtask : sc_iret

	// mid-run reset: all state back to zero, first fetch at phase 0 again
	task automatic sc_reset;
		sys_rst_in = 1'b1;
		repeat (3) @(posedge mclk_in);
		#DRV;
		check(16'(pc_out), 16'h0000, "reset pc");
		check(16'(w_out), 16'h0000, "reset w");
		check(16'(zero_flag_out), 16'h0000, "reset zero");
		check(16'(interrupt_control_reg_out), 16'h0000, "reset en");
		check(16'(cycle_end_out), 16'h0000, "reset cycle end");
		check(16'(fwr_en_out), 16'h0000, "reset strobe");
		sys_rst_in = 1'b0;
		exp_pc = 13'h0000;
		skip = 1'b0;
		stk.delete();
		// f127 held 0x42 before the reset, now it must read zero
		exec(14'h087f, 1'b0);
		check(16'(w_out), 16'h0000, "reset file reg");
		check(16'(zero_flag_out), 16'h0001, "reset file zero");
	endtask : sc_reset

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		mclk_in = 1'b0;
		sys_rst_in = 1'b1;
		instr_in = 14'h0000;
		stack_push_in = 1'b0;
		stack_push_addr_in = 13'h0000;
		irq_en_clear_in = 1'b0;
		miscompares = 0;
		compares = 0;
		exp_pc = 13'h0000;
		skip = 1'b0;
		repeat (10) @(posedge mclk_in);
		#DRV;
		sys_rst_in = 1'b0;
		sc_move();
		sc_literal();
		sc_store();
		sc_nop();
		sc_iret();
		sc_reset();
		complete_run();
	end

	// a stuck run is cut off after 20,000 clocks, far beyond the length of a normal run
	initial begin
		#(20_000 * 50);
		miscompares++;
		complete_run();
	end
endmodule : test_move_nop_interrupt_return_op_decode
